/* gcfg_pkg.sv */
// shared constants and types for the global event and interrupt config
package gcfg_pkg;
    localparam int NUM_FRAMERS = 4;
    localparam int EVT_W = 8;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;

    localparam logic [ADDR_W-1:0] GLOBAL_CONFIGURATION_OFFSET = 12'h006;
    localparam logic [DATA_W-1:0] GLOBAL_CONFIGURATION_RESET = 8'h80;
    localparam logic [DATA_W-1:0] GLOBAL_CONFIGURATION_RSVD = 8'h06;

    localparam int BIT_MASTER_IRQ_BLOCK = 7;
    localparam int BIT_RISE_SELECT = 6;
    localparam int BIT_FALL_SELECT = 5;
    localparam int BIT_IRQ_OUTPUT_INVERT = 4;
    localparam int BIT_MONITOR_SHADOW_ENABLE = 3;
    localparam int BIT_ALARM_SUPPRESSION_ENABLE = 0;

    localparam int EVT_LOS = 7;
    localparam int EVT_AIS = 6;
    localparam int EVT_OOF = 5;
    localparam int EVT_YEL = 4;
    localparam int EVT_CFA = 3;
    localparam int EVT_SEF = 2;
    localparam int EVT_TXSLIP = 1;
    localparam int EVT_RXSLIP = 0;

    typedef logic [EVT_W-1:0] evt_t;

    typedef struct packed {
        logic master_irq_block;
        logic rise_select;
        logic fall_select;
        logic irq_output_invert;
        logic monitor_shadow_enable;
        logic [1:0] reserved;
        logic alarm_suppression_enable;
    } global_cfg_s;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } host_req_s;
endpackage

/* event_latch.sv */
// per-framer edge detector and sticky latched event bits
`timescale 1ns/1ps
module event_latch #(
    parameter int W = 8
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [W-1:0] status_i,
    input wire logic rise_i,
    input wire logic fall_i,
    input wire logic [W-1:0] clear_i,
    output logic [W-1:0] latched_o
);
    logic [W-1:0] prev;
    logic [W-1:0] next_prev;
    logic [W-1:0] next_latched;
    logic [W-1:0] set_ev;

    always_comb begin
        set_ev = '0;
        if (rise_i) begin
            set_ev = set_ev | (status_i & ~prev);
        end
        if (fall_i) begin
            set_ev = set_ev | (~status_i & prev);
        end
        next_prev = status_i;
        // set beats a clear landing in the same cycle
        next_latched = (latched_o & ~clear_i) | set_ev;
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            prev <= '0;
            latched_o <= '0;
        end else begin
            prev <= next_prev;
            latched_o <= next_latched;
        end
    end
endmodule // event_latch

/* global_event_interrupt_config.sv */
// global config register, event latching, alarm suppression and irq pin
`timescale 1ns/1ps
module global_event_interrupt_config #(
    parameter int NUM_FRAMERS = gcfg_pkg::NUM_FRAMERS
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire gcfg_pkg::host_req_s host_i,
    output logic [gcfg_pkg::DATA_W-1:0] rdata_o,
    input wire logic alt_bus_i,
    input wire logic one_second_pulse_input_i,
    input wire gcfg_pkg::evt_t [NUM_FRAMERS-1:0] status_i,
    input wire gcfg_pkg::evt_t [NUM_FRAMERS-1:0] event_mask_i,
    input wire gcfg_pkg::evt_t [NUM_FRAMERS-1:0] latch_clear_i,
    output wire gcfg_pkg::evt_t [NUM_FRAMERS-1:0] latched_o,
    output gcfg_pkg::evt_t [NUM_FRAMERS-1:0] shadow_o,
    output gcfg_pkg::evt_t global_status_o,
    output logic counter_latch_o,
    output logic irq_o
);
    import gcfg_pkg::*;

    global_cfg_s cfg;
    global_cfg_s next_cfg;
    logic [DATA_W-1:0] next_rdata;
    wire evt_t [NUM_FRAMERS-1:0] sup;
    evt_t [NUM_FRAMERS-1:0] next_shadow;
    evt_t next_global;
    logic prev_sec;
    logic sec_rise;
    logic next_counter_latch;
    logic irq_active;
    logic idle_level;
    logic next_irq;

    // LOS, AIS and OOF each hide the alarms below them, except CFA and SEF, in the line-to-system path
    function automatic evt_t suppress(input evt_t s, input logic en);
        evt_t r;
        r = s;
        if (en) begin
            if (s[EVT_LOS]) begin
                r[EVT_AIS] = 1'b0;
            end
            if (s[EVT_LOS] || s[EVT_AIS]) begin
                r[EVT_OOF] = 1'b0;
            end
            if (s[EVT_LOS] || s[EVT_AIS] || s[EVT_OOF]) begin
                r[EVT_YEL] = 1'b0;
                r[EVT_TXSLIP] = 1'b0;
                r[EVT_RXSLIP] = 1'b0;
            end
        end
        return r;
    endfunction

    // register port
    always_comb begin
        next_cfg = cfg;
        next_rdata = '0;
        if (host_i.wr && host_i.addr == GLOBAL_CONFIGURATION_OFFSET) begin
            // reserved bits are kept at zero whatever the host writes
            next_cfg = global_cfg_s'(host_i.wdata
                & ~GLOBAL_CONFIGURATION_RSVD);
        end
        if (host_i.rd && host_i.addr == GLOBAL_CONFIGURATION_OFFSET) begin
            next_rdata = cfg;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cfg <= global_cfg_s'(GLOBAL_CONFIGURATION_RESET);
            rdata_o <= '0;
        end else begin
            cfg <= next_cfg;
            rdata_o <= next_rdata;
        end
    end

    // one shared config fans out to every framer
    for (genvar f = 0; f < NUM_FRAMERS; f++) begin : g_framer
        assign sup[f] = suppress(status_i[f],
            cfg.alarm_suppression_enable);
        event_latch #(
            .W(EVT_W)
        ) u_latch (
            .clk_i(clk_i),
            .rst_n_i(rst_n_i),
            .status_i(sup[f]),
            .rise_i(cfg.rise_select),
            .fall_i(cfg.fall_select),
            .clear_i(latch_clear_i[f]),
            .latched_o(latched_o[f])
        );
    end

    // status, monitoring and interrupt
    always_comb begin
        next_global = '0;
        irq_active = 1'b0;
        next_shadow = shadow_o;
        for (int f = 0; f < NUM_FRAMERS; f++) begin
            next_global = next_global | latched_o[f];
            irq_active = irq_active
                | (|(latched_o[f] & ~event_mask_i[f]));
        end
        sec_rise = one_second_pulse_input_i & ~prev_sec;
        next_counter_latch = cfg.monitor_shadow_enable
            & sec_rise;
        if (next_counter_latch) begin
            next_shadow = latched_o;
        end
        // inactive level: low on the default bus, high on the alternate, both swapped when irq_output_invert is set
        idle_level = alt_bus_i ^ cfg.irq_output_invert;
        if (cfg.master_irq_block) begin
            next_irq = idle_level;
        end else begin
            next_irq = irq_active ^ idle_level;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            global_status_o <= '0;
            shadow_o <= '0;
            prev_sec <= 1'b0;
            counter_latch_o <= 1'b0;
            irq_o <= 1'b0;
        end else begin
            global_status_o <= next_global;
            shadow_o <= next_shadow;
            prev_sec <= one_second_pulse_input_i;
            counter_latch_o <= next_counter_latch;
            irq_o <= next_irq;
        end
    end

    // helpers for checks on framer 0, change of alignment bit
    logic s0;
    logic l0;
    logic c0;
    assign s0 = sup[0][EVT_CFA];
    assign l0 = latched_o[0][EVT_CFA];
    assign c0 = latch_clear_i[0][EVT_CFA];

    irq_blocked_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        cfg.master_irq_block |=> irq_o == $past(idle_level))
        else $error("interrupt not inactive while blocked");

    irq_raise_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        !cfg.master_irq_block && irq_active |=> irq_o != $past(idle_level))
        else $error("unmasked event did not assert interrupt");

    rise_only_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        $rose(l0) && $past(cfg.rise_select) && !$past(cfg.fall_select)
        |-> $past(s0) && !$past(s0, 2))
        else $error("latched bit set without a rising edge");

    both_edges_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        $past(cfg.rise_select) && $past(cfg.fall_select)
        && ($past(s0) != $past(s0, 2)) |-> l0)
        else $error("transition not latched with both edges selected");

    no_edge_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        !$past(cfg.rise_select) && !$past(cfg.fall_select) && !$past(l0)
        |-> !l0)
        else $error("latched bit set with no edge selected");

    shadow_update_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        cfg.monitor_shadow_enable && one_second_pulse_input_i && !prev_sec
        |=> counter_latch_o && shadow_o == $past(latched_o))
        else $error("one-second edge missed while monitoring on");

    shadow_off_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        !cfg.monitor_shadow_enable |=> !counter_latch_o && $stable(shadow_o))
        else $error("shadow moved while monitoring off");

    suppress_order_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        cfg.alarm_suppression_enable && status_i[0][EVT_AIS]
        |-> !sup[0][EVT_OOF] && !sup[0][EVT_YEL] && !sup[0][EVT_TXSLIP])
        else $error("lower alarm not suppressed under ais");

    reserved_zero_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        host_i.wr |=> cfg.reserved == 2'h0)
        else $error("reserved config bits hold a one");

    irq_invert_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        !alt_bus_i && cfg.irq_output_invert && !irq_active |=> irq_o)
        else $error("inverted interrupt not idle high on default bus");

    latch_sticky_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        $past(rst_n_i) && $past(l0) && !$past(c0) |-> l0)
        else $error("latched event dropped without a clear");

    latch_clear_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        $past(c0) && !$past(cfg.rise_select) && !$past(cfg.fall_select)
        |-> !l0)
        else $error("clear ignored with no edge selected");
endmodule // global_event_interrupt_config

/* host_cpu_model.sv */
// host processor model for the global configuration register
`timescale 1ns/1ps
module host_cpu_model (
    input wire logic clk_i,
    output gcfg_pkg::host_req_s host_o,
    input wire logic [gcfg_pkg::DATA_W-1:0] rdata_i
);
    import gcfg_pkg::*;
    initial host_o = '0;
    // idle address is scrambled so a stale strobe cannot hit by luck
    task automatic put(input logic [11:0] a, input logic [7:0] d);
        @(negedge clk_i);
        host_o.addr = a;
        host_o.wdata = d & ~GLOBAL_CONFIGURATION_RSVD;
        host_o.wr = 1'b1;
        @(negedge clk_i);
        host_o.wr = 1'b0;
        host_o.addr = ~a;
    endtask
    task automatic get(input logic [11:0] a, output logic [7:0] d);
        @(negedge clk_i);
        host_o.addr = a;
        host_o.rd = 1'b1;
        @(negedge clk_i);
        host_o.rd = 1'b0;
        host_o.addr = ~a;
        d = rdata_i;
    endtask
endmodule // host_cpu_model

/* global_event_interrupt_config_test.sv */
// testbench for the global event and interrupt configuration block
`timescale 1ns/1ps
module global_event_interrupt_config_test;
    import gcfg_pkg::*;
    logic clk_i, rst_n_i, alt_bus_i, one_second_pulse_input_i;
    host_req_s host_i;
    logic [7:0] rdata_o, rv, cfg;
    evt_t [3:0] status_i, event_mask_i, latch_clear_i, latched_o, shadow_o;
    evt_t global_status_o;
    logic counter_latch_o, irq_o;
    int n_mismatch = 0;
    int checks = 0;
    global_event_interrupt_config dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .host_i(host_i), .rdata_o(rdata_o), .alt_bus_i(alt_bus_i),
        .one_second_pulse_input_i(one_second_pulse_input_i),
        .status_i(status_i), .event_mask_i(event_mask_i),
        .latch_clear_i(latch_clear_i), .latched_o(latched_o),
        .shadow_o(shadow_o), .global_status_o(global_status_o),
        .counter_latch_o(counter_latch_o), .irq_o(irq_o));
    host_cpu_model host_u (.clk_i(clk_i), .host_o(host_i), .rdata_i(rdata_o));
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    // status must stay put here, else set wins over clear
    task automatic clr();
        latch_clear_i = '1;
        tick(1);
        latch_clear_i = '0;
    endtask
    task automatic t_reg();
        host_u.get(GLOBAL_CONFIGURATION_OFFSET, rv);
        chk(rv, 8'h80);
        chk(irq_o, 1'b0);
        host_u.put(GLOBAL_CONFIGURATION_OFFSET, 8'h59);
        host_u.get(GLOBAL_CONFIGURATION_OFFSET, rv);
        chk(rv, 8'h59);
        host_u.get(12'h007, rv);
        chk(rv, 8'h00);
    endtask
    task automatic t_edges();
        for (int i = 0; i < 4; i++) begin
            cfg = {1'b0, i[1], i[0], 5'h00};
            host_u.put(GLOBAL_CONFIGURATION_OFFSET, cfg);
            // every framer sees the same edge under one shared setting
            for (int k = 0; k < 4; k++) begin
                status_i[k][EVT_CFA] = 1'b1;
            end
            tick(1);
            chk(latched_o, {4{4'h0, cfg[6], 3'h0}});
            tick(1);
            chk(irq_o, cfg[6]);
            clr();
            for (int k = 0; k < 4; k++) begin
                status_i[k][EVT_CFA] = 1'b0;
            end
            tick(1);
            chk(latched_o, {4{4'h0, cfg[5], 3'h0}});
            clr();
        end
    endtask
    task automatic t_mask();
        host_u.put(GLOBAL_CONFIGURATION_OFFSET, 8'h40);
        event_mask_i[1] = '1;
        status_i[1][EVT_SEF] = 1'b1;
        tick(2);
        chk(global_status_o, 8'h04);
        chk(irq_o, 1'b0);
        event_mask_i = '0;
        tick(2);
        chk(irq_o, 1'b1);
        // event left latched so polarity is seen both idle and active
        for (int j = 0; j < 8; j++) begin
            alt_bus_i = j[0];
            host_u.put(GLOBAL_CONFIGURATION_OFFSET, {j[2], 2'b10, j[1], 4'h0});
            tick(1);
            // braces keep the inversion one bit wide
            chk(irq_o, {~j[2] ^ j[0] ^ j[1]});
        end
        alt_bus_i = 1'b0;
    endtask
    task automatic t_second();
        host_u.put(GLOBAL_CONFIGURATION_OFFSET, 8'h48);
        status_i[3][EVT_YEL] = 1'b1;
        tick(1);
        one_second_pulse_input_i = 1'b1;
        tick(1);
        chk(counter_latch_o, 1'b1);
        chk(shadow_o[3], 8'h10);
        tick(1);
        chk(counter_latch_o, 1'b0);
        one_second_pulse_input_i = 1'b0;
        host_u.put(GLOBAL_CONFIGURATION_OFFSET, 8'h40);
        one_second_pulse_input_i = 1'b1;
        tick(1);
        chk(counter_latch_o, 1'b0);
        chk(shadow_o[3], 8'h10);
        one_second_pulse_input_i = 1'b0;
    endtask
    task automatic t_supp();
        status_i = '0;
        tick(1);
        clr();
        host_u.put(GLOBAL_CONFIGURATION_OFFSET, 8'h41);
        status_i[0] = 8'ha8;
        tick(1);
        chk(latched_o[0], 8'h88);
        status_i[0][EVT_LOS] = 1'b0;
        tick(1);
        chk(latched_o[0], 8'ha8);
        // ais rises and hides oof, yellow and transmit slip
        status_i[0] = 8'h72;
        tick(1);
        chk(latched_o[0], 8'he8);
    endtask
    task automatic tally_and_finish();
        $display("mismatches=%0d checks=%0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        rst_n_i = 1'b0;
        alt_bus_i = 1'b0;
        one_second_pulse_input_i = 1'b0;
        status_i = '0;
        event_mask_i = '0;
        latch_clear_i = '0;
        tick(4);
        rst_n_i = 1'b1;
        t_reg();
        t_edges();
        t_mask();
        t_second();
        t_supp();
        tally_and_finish();
    end
endmodule // global_event_interrupt_config_test
